// >>> include/fslb_defs.vh
// Constants of the fault-status latch bank: address, bit positions, reset value, timing.
// Assumes inclusion by bare name from the design files.
`ifndef FSLB_DEFS_VH
`define FSLB_DEFS_VH

`define FSLB_ADDR 6'h32
`define FSLB_WIDTH 24
`define FSLB_RESET_VALUE 24'h000000

`define FSLB_BIT_BUS_DOM 23
`define FSLB_BIT_TXD_DOM 22
`define FSLB_BIT_BUS_REC 21
`define FSLB_BIT_DS_HI 15
`define FSLB_BIT_DS_LO 12
`define FSLB_BIT_INV_CMD 11
`define FSLB_BIT_SCK_CNT 10
`define FSLB_BIT_PUMP_VOLTAGE_LOW_FLAG 9
`define FSLB_BIT_TW 8
`define FSLB_BIT_V2SHORT 7
`define FSLB_BIT_REGULATOR_TWO_FAIL_FLAG 6
`define FSLB_BIT_REGULATOR_ONE_FAIL_FLAG 5
`define FSLB_BIT_EW 4
`define FSLB_BIT_SUP_HI 3
`define FSLB_BIT_SUP_LO 0

`define FSLB_CLOCK_HZ 50000000
`define FSLB_INT_PULSE_NS 2000
`define FSLB_INT_PULSE_CYCLES ((`FSLB_INT_PULSE_NS * (`FSLB_CLOCK_HZ / 1000000) + 999) / 1000)

`endif

// >>> verilog/fslb_fault_status_latch_bank.v
// Latched fault-status register with read-and-clear, LIN transmitter lockout and early warning pulse.
// Assumes a serial frame decoder on CLOCK_I reports each finished frame with its checks;
// fault detector levels come from analog or pin domains and are synchronised here.
// Operation
// - Bit 23 latches bus dominant beyond timeout until read-and-clear.
// - Bit 22 latches transmit input dominant timeout; transmitter disabled while set.
// - Bit 21 latches bus not following transmit input; transmitter disabled while set.
// - Bits 15..12 latch one bridge drain-source fault each until read-and-clear.
// - Bit 11 latches any invalid serial command condition.
// - A frame with an invalid command is discarded; it clears nothing and only latches bit 11 (and bit 10 on a wrong clock count).
// - Bit 10 sets when a frame has the wrong clock count.
// - Bit 10 clears only on the next correctly formed frame.
// - Bit 9 latches charge pump voltage low until read-and-clear.
// - Bit 8 latches the OR of all cluster thermal warnings.
// - Bit 7 latches second regulator short during its turn-on.
// - Bit 6 latches second regulator fail since last readout.
// - Bit 5 latches first regulator fail since last readout.
// - Bit 4 latches early warning; interrupt pulse only in Active mode.
// - Bits 3..0 latch supply over/undervoltage flags until read-and-clear.
`timescale 1ns/100ps
`default_nettype none
`include "fslb_defs.vh"

module fslb_fault_status_latch_bank #(
    parameter CLUSTERS = 4,
    parameter INT_PULSE_CYCLES = `FSLB_INT_PULSE_CYCLES
) (
    input wire CLOCK_I,
    input wire RESET_N_I,
    input wire BUS_DOMINANT_TIMEOUT_I,
    input wire TRANSMIT_INPUT_DOMINANT_TIMEOUT_I,
    input wire BUS_NOT_FOLLOWING_I,
    input wire [3:0] BRIDGE_MONITOR_FAULT_I,
    input wire PUMP_VOLTAGE_LOW_I,
    input wire [CLUSTERS-1:0] CLUSTER_THERMAL_WARNING_I,
    input wire REGULATOR_TWO_SHORT_I,
    input wire REGULATOR_TWO_FAIL_I,
    input wire REGULATOR_ONE_FAIL_I,
    input wire SUPPLY_EARLY_WARNING_I,
    input wire [3:0] SUPPLY_VOLTAGE_FAULT_I,
    input wire ACTIVE_MODE_I,
    input wire FRAME_END_I,
    input wire [5:0] FRAME_ADDR_I,
    input wire FRAME_READ_CLEAR_I,
    input wire FRAME_CLOCK_COUNT_BAD_I,
    input wire FRAME_UNDEFINED_ADDR_I,
    input wire FRAME_STATUS_WRITE_I,
    input wire FRAME_DATA_STUCK_I,
    input wire FRAME_SELECT_TIMEOUT_I,
    input wire FRAME_PARITY_ERROR_I,
    input wire FRAME_UNDEFINED_SETTING_I,
    output wire [23:0] STATUS_O,
    output wire [23:0] READ_DATA_O,
    output wire READ_DATA_VALID_O,
    output wire FRAME_APPLY_O,
    output wire FRAME_DISCARD_O,
    output wire LIN_TRANSMIT_DISABLE_O,
    output wire INTERRUPT_OUTPUT_PIN_N_O
);

    // Counter is 16 bits; longer pulses would need a wider counter
    localparam [31:0] PULSE_LEN_FULL = INT_PULSE_CYCLES;
    localparam [15:0] PULSE_LEN = PULSE_LEN_FULL[15:0];

    // ==========================================================
    // Detector synchronisers
    // ==========================================================
    localparam NSYNC = 16 + CLUSTERS;
    wire [NSYNC-1:0] raw_in;
    reg [NSYNC-1:0] sync1_reg;
    reg [NSYNC-1:0] sync2_reg;

    assign raw_in = {CLUSTER_THERMAL_WARNING_I, SUPPLY_VOLTAGE_FAULT_I, SUPPLY_EARLY_WARNING_I,
                     REGULATOR_ONE_FAIL_I, REGULATOR_TWO_FAIL_I, REGULATOR_TWO_SHORT_I,
                     PUMP_VOLTAGE_LOW_I, BRIDGE_MONITOR_FAULT_I, BUS_NOT_FOLLOWING_I,
                     TRANSMIT_INPUT_DOMINANT_TIMEOUT_I, BUS_DOMINANT_TIMEOUT_I};

    always @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sync1_reg <= {NSYNC{1'b0}};
            sync2_reg <= {NSYNC{1'b0}};
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    wire bus_dom_s = sync2_reg[0];
    wire txd_dom_s = sync2_reg[1];
    wire bus_rec_s = sync2_reg[2];
    wire [3:0] bridge_s = sync2_reg[6:3];
    wire pump_low_s = sync2_reg[7];
    wire v2_short_s = sync2_reg[8];
    wire v2_fail_s = sync2_reg[9];
    wire v1_fail_s = sync2_reg[10];
    wire early_warn_s = sync2_reg[11];
    wire [3:0] supply_s = sync2_reg[15:12];
    wire [CLUSTERS-1:0] cluster_tw_s = sync2_reg[NSYNC-1:16];

    // ==========================================================
    // Frame classification
    // ==========================================================
    // Qualifiers mean nothing outside the FRAME_END_I cycle
    wire invalid_cmd = FRAME_UNDEFINED_ADDR_I | FRAME_STATUS_WRITE_I | FRAME_DATA_STUCK_I |
                       FRAME_SELECT_TIMEOUT_I | FRAME_PARITY_ERROR_I | FRAME_UNDEFINED_SETTING_I;
    wire frame_bad = FRAME_END_I & (invalid_cmd | FRAME_CLOCK_COUNT_BAD_I);
    wire frame_good = FRAME_END_I & ~invalid_cmd & ~FRAME_CLOCK_COUNT_BAD_I;
    // A discarded frame must not clear anything, so read-and-clear needs a good frame
    wire read_clear = frame_good & FRAME_READ_CLEAR_I & (FRAME_ADDR_I == `FSLB_ADDR);

    assign FRAME_APPLY_O = frame_good;
    assign FRAME_DISCARD_O = frame_bad;

    // ==========================================================
    // Status flags
    // ==========================================================
    reg [23:0] status_reg;
    reg [23:0] status_next;
    reg [23:0] set_vec;

    always @* begin
        set_vec = 24'h000000;
        set_vec[`FSLB_BIT_BUS_DOM] = bus_dom_s;
        set_vec[`FSLB_BIT_TXD_DOM] = txd_dom_s;
        set_vec[`FSLB_BIT_BUS_REC] = bus_rec_s;
        set_vec[`FSLB_BIT_DS_HI:`FSLB_BIT_DS_LO] = bridge_s;
        set_vec[`FSLB_BIT_INV_CMD] = FRAME_END_I & invalid_cmd;
        set_vec[`FSLB_BIT_SCK_CNT] = FRAME_END_I & FRAME_CLOCK_COUNT_BAD_I;
        set_vec[`FSLB_BIT_PUMP_VOLTAGE_LOW_FLAG] = pump_low_s;
        set_vec[`FSLB_BIT_TW] = |cluster_tw_s;
        set_vec[`FSLB_BIT_V2SHORT] = v2_short_s;
        set_vec[`FSLB_BIT_REGULATOR_TWO_FAIL_FLAG] = v2_fail_s;
        set_vec[`FSLB_BIT_REGULATOR_ONE_FAIL_FLAG] = v1_fail_s;
        set_vec[`FSLB_BIT_EW] = early_warn_s;
        set_vec[`FSLB_BIT_SUP_HI:`FSLB_BIT_SUP_LO] = supply_s;

        status_next = status_reg;
        if (read_clear) begin
            status_next = 24'h000000;
            // Clock-count flag is kept here; the good-frame clear below still drops it
            status_next[`FSLB_BIT_SCK_CNT] = status_reg[`FSLB_BIT_SCK_CNT];
        end
        if (frame_good) begin
            status_next[`FSLB_BIT_SCK_CNT] = 1'b0;
        end
        // Set wins over clear so an event in the clearing cycle is kept
        status_next = status_next | set_vec;
    end

    // ==========================================================
    // Read capture
    // ==========================================================
    reg [23:0] read_data_reg;
    reg read_valid_reg;

    always @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            status_reg <= `FSLB_RESET_VALUE;
            read_data_reg <= `FSLB_RESET_VALUE;
            read_valid_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            read_valid_reg <= read_clear;
            if (read_clear) begin
                read_data_reg <= status_reg;
            end
        end
    end

    assign STATUS_O = status_reg;
    assign READ_DATA_O = read_data_reg;
    assign READ_DATA_VALID_O = read_valid_reg;

    // ==========================================================
    // LIN transmitter lockout
    // ==========================================================
    // Bus dominant flag alone never locks the transmitter out
    // Lockout tracks the flags directly; it lifts the cycle the flag clears
    reg lin_dis_reg;
    always @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            lin_dis_reg <= 1'b0;
        end else begin
            lin_dis_reg <= status_next[`FSLB_BIT_TXD_DOM] | status_next[`FSLB_BIT_BUS_REC];
        end
    end
    assign LIN_TRANSMIT_DISABLE_O = lin_dis_reg;

    // ==========================================================
    // Early warning interrupt pulse
    // ==========================================================
    // Pulse only on a fresh latch; a flag left set by the host gives no repeats
    wire ew_rise = status_next[`FSLB_BIT_EW] & ~status_reg[`FSLB_BIT_EW];
    reg [15:0] pulse_cnt_reg;
    reg [15:0] pulse_cnt_next;
    reg int_n_reg;

    // Mode is taken with the rise itself; a later switch to Active gives no late pulse
    always @* begin
        pulse_cnt_next = pulse_cnt_reg;
        if (ew_rise && ACTIVE_MODE_I) begin
            pulse_cnt_next = PULSE_LEN;
        end else if (pulse_cnt_reg != 16'h0000) begin
            pulse_cnt_next = pulse_cnt_reg - 16'h0001;
        end
    end

    // Pin comes from a flop so counter decodes cannot glitch onto it
    always @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pulse_cnt_reg <= 16'h0000;
            int_n_reg <= 1'b1;
        end else begin
            pulse_cnt_reg <= pulse_cnt_next;
            int_n_reg <= (pulse_cnt_next == 16'h0000);
        end
    end
    assign INTERRUPT_OUTPUT_PIN_N_O = int_n_reg;

endmodule // fslb_fault_status_latch_bank

`default_nettype wire

// >>> dv/fslb_host_model.sv
// Host model: issues serial frames as decoded one-cycle frame reports.
// Assumes the bench calls send; qualifiers drive inverted outside frames.
`timescale 1ns/100ps
`default_nettype none
module fslb_host_model (
    input wire logic clock_i,
    output logic frame_end_o,
    output logic [5:0] frame_addr_o,
    output logic frame_rc_o,
    output logic [6:0] frame_err_o
);
    initial begin
        frame_end_o = 1'b0;
        frame_addr_o = 6'h00;
        frame_rc_o = 1'b0;
        frame_err_o = 7'h00;
    end
    // Err bit 0 wrong clock count, bits 6:1 invalid-command causes
    task send(input logic [5:0] addr, input logic rc, input logic [6:0] err);
        @(negedge clock_i);
        frame_end_o = 1'b1;
        frame_addr_o = addr;
        frame_rc_o = rc;
        frame_err_o = err;
        @(negedge clock_i);
        frame_end_o = 1'b0;
        frame_addr_o = ~addr;
        frame_rc_o = ~rc;
        frame_err_o = ~err;
    endtask
endmodule // fslb_host_model
`default_nettype wire

// >>> dv/fslb_fault_status_latch_bank_assertions.sv
// Checker of the fault-status latch bank ports.
// Assumes bind onto the design; low reset disables every check.
`timescale 1ns/100ps
`default_nettype none
module fslb_checker (
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    input wire logic ACTIVE_MODE_I,
    input wire logic FRAME_END_I,
    input wire logic [5:0] FRAME_ADDR_I,
    input wire logic FRAME_READ_CLEAR_I,
    input wire logic FRAME_CLOCK_COUNT_BAD_I,
    input wire logic [23:0] STATUS_O,
    input wire logic [23:0] READ_DATA_O,
    input wire logic READ_DATA_VALID_O,
    input wire logic FRAME_APPLY_O,
    input wire logic FRAME_DISCARD_O,
    input wire logic LIN_TRANSMIT_DISABLE_O,
    input wire logic INTERRUPT_OUTPUT_PIN_N_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESET_N_I);
    wire rc_ok = FRAME_APPLY_O & FRAME_READ_CLEAR_I & (FRAME_ADDR_I == 6'h32);
    a_lockout_tracks: assert property (LIN_TRANSMIT_DISABLE_O == (STATUS_O[22] | STATUS_O[21]))
        else $error("lockout mismatch");
    a_flags_hold: assert property (!rc_ok |=> ($past(STATUS_O) & ~STATUS_O & 24'hE0FBFF) == 24'h0)
        else $error("flag fell without clear");
    a_count_sticky: assert property (STATUS_O[10] && !FRAME_APPLY_O |=> STATUS_O[10])
        else $error("count flag fell");
    a_count_clear: assert property (FRAME_APPLY_O |=> !STATUS_O[10])
        else $error("count flag kept");
    a_count_set: assert property (FRAME_END_I && FRAME_CLOCK_COUNT_BAD_I |=> STATUS_O[10] && !READ_DATA_VALID_O)
        else $error("count flag missing");
    a_invalid_set: assert property (FRAME_DISCARD_O && !FRAME_CLOCK_COUNT_BAD_I |=> STATUS_O[11])
        else $error("invalid flag missing");
    a_discard_keeps: assert property (FRAME_DISCARD_O |=> ($past(STATUS_O) & ~STATUS_O) == 24'h0)
        else $error("discarded frame cleared");
    a_frame_verdict: assert property (FRAME_END_I |-> FRAME_APPLY_O != FRAME_DISCARD_O)
        else $error("frame verdict wrong");
    a_read_back: assert property (rc_ok |=> READ_DATA_VALID_O && READ_DATA_O == $past(STATUS_O))
        else $error("read data wrong");
    a_int_cause: assert property ($fell(INTERRUPT_OUTPUT_PIN_N_O) |-> $rose(STATUS_O[4]) && $past(ACTIVE_MODE_I))
        else $error("stray interrupt");
    c_read_clear: cover property (rc_ok);
    c_discard: cover property (FRAME_DISCARD_O);
    c_interrupt: cover property ($fell(INTERRUPT_OUTPUT_PIN_N_O));
endmodule // fslb_checker
bind fslb_fault_status_latch_bank fslb_checker fslb_checker_i (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I),
    .ACTIVE_MODE_I(ACTIVE_MODE_I), .FRAME_END_I(FRAME_END_I), .FRAME_ADDR_I(FRAME_ADDR_I),
    .FRAME_READ_CLEAR_I(FRAME_READ_CLEAR_I), .FRAME_CLOCK_COUNT_BAD_I(FRAME_CLOCK_COUNT_BAD_I),
    .STATUS_O(STATUS_O), .READ_DATA_O(READ_DATA_O), .READ_DATA_VALID_O(READ_DATA_VALID_O),
    .FRAME_APPLY_O(FRAME_APPLY_O), .FRAME_DISCARD_O(FRAME_DISCARD_O),
    .LIN_TRANSMIT_DISABLE_O(LIN_TRANSMIT_DISABLE_O), .INTERRUPT_OUTPUT_PIN_N_O(INTERRUPT_OUTPUT_PIN_N_O));
`default_nettype wire

// >>> dv/fslb_testbench.sv
// Self-checking bench of the fault-status latch bank.
// Assumes design, host model and checker compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic active = 1'b1;
    logic [23:0] cond = 24'h0;
    logic [3:0] clu = 4'h0;
    logic fe;
    logic frc;
    logic [5:0] fa;
    logic [6:0] ferr;
    wire [23:0] st;
    wire [23:0] rd;
    wire dis;
    wire int_n;
    integer err_total = 0;
    integer n_tests = 0;
    integer i;
    integer n;
    always #10 clk = ~clk;
    fslb_host_model fslb_host_model_i (.clock_i(clk), .frame_end_o(fe), .frame_addr_o(fa), .frame_rc_o(frc),
        .frame_err_o(ferr));
    // Short pulse keeps the run brief
    fslb_fault_status_latch_bank #(.INT_PULSE_CYCLES(3)) fslb_fault_status_latch_bank_i (.CLOCK_I(clk),
        .RESET_N_I(rst_n), .BUS_DOMINANT_TIMEOUT_I(cond[23]), .TRANSMIT_INPUT_DOMINANT_TIMEOUT_I(cond[22]),
        .BUS_NOT_FOLLOWING_I(cond[21]), .BRIDGE_MONITOR_FAULT_I(cond[15:12]), .PUMP_VOLTAGE_LOW_I(cond[9]),
        .CLUSTER_THERMAL_WARNING_I(clu), .REGULATOR_TWO_SHORT_I(cond[7]), .REGULATOR_TWO_FAIL_I(cond[6]),
        .REGULATOR_ONE_FAIL_I(cond[5]), .SUPPLY_EARLY_WARNING_I(cond[4]), .SUPPLY_VOLTAGE_FAULT_I(cond[3:0]),
        .ACTIVE_MODE_I(active), .FRAME_END_I(fe), .FRAME_ADDR_I(fa), .FRAME_READ_CLEAR_I(frc),
        .FRAME_CLOCK_COUNT_BAD_I(ferr[0]), .FRAME_UNDEFINED_ADDR_I(ferr[1]), .FRAME_STATUS_WRITE_I(ferr[2]),
        .FRAME_DATA_STUCK_I(ferr[3]), .FRAME_SELECT_TIMEOUT_I(ferr[4]), .FRAME_PARITY_ERROR_I(ferr[5]),
        .FRAME_UNDEFINED_SETTING_I(ferr[6]), .STATUS_O(st), .READ_DATA_O(rd), .READ_DATA_VALID_O(),
        .FRAME_APPLY_O(), .FRAME_DISCARD_O(), .LIN_TRANSMIT_DISABLE_O(dis), .INTERRUPT_OUTPUT_PIN_N_O(int_n));
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("Mismatches %0d of %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Counts interrupt-low cycles over a fixed span
    task count_low;
        n = 0;
        for (i = 0; i < 10; i++) begin
            @(negedge clk);
            n += (int_n === 1'b0);
        end
    endtask
    task rc_idle;
        repeat (3) @(negedge clk);
        fslb_host_model_i.send(6'h32, 1'b1, 7'h00);
    endtask
    initial begin
        #200000;
        err_total++;
        final_report;
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        chk({st[21:0], dis, int_n}, 24'h000001);
        cond = 24'hE0F3FF;
        clu = 4'h4;
        count_low;
        chk(st, 24'hE0F3FF);
        chk({23'h0, dis}, 24'h000001);
        chk(n[23:0], 24'h000003);
        cond = 24'h000200;
        clu = 4'h0;
        rc_idle;
        chk(rd, 24'hE0F3FF);
        chk({st[22:0], dis}, 24'h000400);
        cond = 24'h000001;
        rc_idle;
        cond = 24'h0;
        repeat (3) @(negedge clk);
        // Discarded read-clears must leave bit 0 standing
        for (integer k = 1; k < 7; k++) begin
            fslb_host_model_i.send(6'h32, 1'b1, 7'h01 << k);
            chk(st, 24'h000801);
        end
        fslb_host_model_i.send(6'h32, 1'b1, 7'h01);
        chk(st, 24'h000C01);
        // Good read-clear to another address: clears the count flag only
        fslb_host_model_i.send(6'h10, 1'b1, 7'h00);
        chk(st, 24'h000801);
        rc_idle;
        chk(rd, 24'h000801);
        chk(st, 24'h000000);
        active = 1'b0;
        cond = 24'h000010;
        count_low;
        chk(n[23:0], 24'h000000);
        chk(st, 24'h000010);
        cond = 24'h0;
        active = 1'b1;
        rc_idle;
        chk(st, 24'h000000);
        final_report;
    end
endmodule // testbench
`default_nettype wire
